// ==== rtl/hmfs_defines.svh ====
`ifndef HMFS_DEFINES_SVH
`define HMFS_DEFINES_SVH

// ******************************
// Device register window
// ******************************
`define HMFS_RX_FIFO_OCCUPANCY  8'h7C
`define HMFS_TX_FIFO_SPACE      8'h80
`define HMFS_RX_DROP_COUNT      8'hA0
`define HMFS_CSR_COMMAND        8'hA4
`define HMFS_CSR_DATA           8'hA8
`define HMFS_CMD_BUSY_BIT       31
`define HMFS_CMD_DIR_BIT        30
`define HMFS_TX_FREE_RESET      16'h1200
`define HMFS_DROP_HALF_POINT    32'h7FFFFFFF

// ******************************
// Controller registers on APB
// ******************************
`define HMFS_H_COMMAND          12'h000
`define HMFS_H_ADDRESS          12'h004
`define HMFS_H_WDATA            12'h008
`define HMFS_H_RDATA            12'h00C
`define HMFS_H_STATUS           12'h010
`define HMFS_H_IRQ_STATUS       12'h014
`define HMFS_H_IRQ_CLEAR        12'h018
`define HMFS_H_IRQ_ENABLE       12'h01C
`define HMFS_H_GO_BIT           0
`define HMFS_H_WRITE_BIT        1
`define HMFS_IRQ_DONE_BIT       0
`define HMFS_IRQ_REFUSED_BIT    1

`endif

// ==== rtl/hmfs_pkg.sv ====
package hmfs_pkg;
   typedef logic [31:0] hmfs_word_t;
   typedef logic [7:0]  hmfs_addr_t;
   typedef enum logic {
      hmfs_idle,
      hmfs_access
   } hmfs_link_state_t;
endpackage

// ==== rtl/hmfs_link_if.sv ====
`timescale 1ns/100ps
interface hmfs_link_if (
   input wire logic pclk,
   input wire logic presetn
);
   logic                req;
   logic                we;
   hmfs_pkg::hmfs_addr_t addr;
   hmfs_pkg::hmfs_word_t wdata;
   hmfs_pkg::hmfs_word_t rdata;
   logic                ack;

   modport dev (
      input  pclk, presetn, req, we, addr, wdata,
      output rdata, ack
   );
   modport host (
      input  pclk, presetn, rdata, ack,
      output req, we, addr, wdata
   );
endinterface

// ==== rtl/hmfs_drop_counter.sv ====
`timescale 1ns/100ps
`include "hmfs_defines.svh"
module hmfs_drop_counter (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // Events
   input  wire logic                 drop,
   input  wire logic                 clear,
   // Results
   output hmfs_pkg::hmfs_word_t      count,
   output logic                      half_flag
);
   hmfs_pkg::hmfs_word_t count_q;
   hmfs_pkg::hmfs_word_t count_d;
   hmfs_pkg::hmfs_word_t base;
   logic                 half_d;
   logic                 half_q;

   // A drop in the clearing cycle survives as a count of one
   assign base    = clear ? 32'h00000000 : count_q;
   assign count_d = base + {31'h00000000, drop};
   assign half_d  = drop && !clear &&
                    (count_q == `HMFS_DROP_HALF_POINT);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= 32'h00000000;
         half_q  <= 1'b0;
      end else begin
         count_q <= count_d;
         half_q  <= half_d;
      end
   end

   assign count     = count_q;
   assign half_flag = half_q;
endmodule

// ==== rtl/hmfs_device.sv ====
`timescale 1ns/100ps
`include "hmfs_defines.svh"
module hmfs_device (
   // Register window
   hmfs_link_if.dev                  link,
   // Rx fifo state
   input  wire logic [7:0]           rx_status_used_dwords,
   input  wire logic                 rx_frame_valid,
   input  wire logic [15:0]          rx_frame_len,
   input  wire logic                 rx_data_read_valid,
   input  wire logic [15:0]          rx_data_read_bytes,
   input  wire logic                 rx_frame_dropped,
   // Tx fifo state
   input  wire logic [7:0]           tx_status_used_dwords,
   input  wire logic                 tx_data_push_valid,
   input  wire logic [15:0]          tx_data_push_bytes,
   input  wire logic                 tx_data_sent_valid,
   input  wire logic [15:0]          tx_data_sent_bytes,
   // Interrupt event
   output logic                      drop_count_half_flag,
   // Internal csr port
   output logic                      csr_req,
   output logic                      csr_access_direction,
   output logic [7:0]                csr_addr,
   output hmfs_pkg::hmfs_word_t      csr_wdata,
   input  wire hmfs_pkg::hmfs_word_t csr_rdata,
   input  wire logic                 csr_ack
);
   // ******************************
   // Functions
   // ******************************
   function automatic logic [15:0] dword_round(input logic [15:0] n);
      logic [15:0] s;
      s = n + 16'h0003;
      dword_round = {s[15:2], 2'b00};
   endfunction

   function automatic logic [15:0] gate16(input logic en,
                                          input logic [15:0] v);
      gate16 = en ? v : 16'h0000;
   endfunction

   // ******************************
   // Bus decode
   // ******************************
   logic                 ack_q;
   hmfs_pkg::hmfs_word_t rdata_q;
   wire  take      = link.req && !ack_q;
   wire  wr        = take && link.we;
   wire  rd        = take && !link.we;
   wire  hit_rxo   = (link.addr == `HMFS_RX_FIFO_OCCUPANCY);
   wire  hit_txs   = (link.addr == `HMFS_TX_FIFO_SPACE);
   wire  hit_drop  = (link.addr == `HMFS_RX_DROP_COUNT);
   wire  hit_cmd   = (link.addr == `HMFS_CSR_COMMAND);
   wire  hit_data  = (link.addr == `HMFS_CSR_DATA);

   // ******************************
   // Fifo occupancy
   // ******************************
   logic [15:0] rx_used_q;
   logic [15:0] rx_used_d;
   logic [15:0] tx_free_q;
   logic [15:0] tx_free_d;

   assign rx_used_d = rx_used_q
                    + gate16(rx_frame_valid,
                             dword_round(rx_frame_len))
                    - gate16(rx_data_read_valid,
                             rx_data_read_bytes);
   // The host keeps pushes within the free space, so no underflow
   assign tx_free_d = tx_free_q
                    + gate16(tx_data_sent_valid, tx_data_sent_bytes)
                    - gate16(tx_data_push_valid,
                             tx_data_push_bytes);

   always_ff @(posedge link.pclk or negedge link.presetn) begin
      if (!link.presetn) begin
         rx_used_q <= 16'h0000;
         tx_free_q <= `HMFS_TX_FREE_RESET;
      end else begin
         rx_used_q <= rx_used_d;
         tx_free_q <= tx_free_d;
      end
   end

   // ******************************
   // Dropped frames
   // ******************************
   hmfs_pkg::hmfs_word_t drop_count;
   wire                  drop_clear = rd && hit_drop;

   hmfs_drop_counter u_drop (
      .pclk      (link.pclk),
      .presetn   (link.presetn),
      .drop      (rx_frame_dropped),
      .clear     (drop_clear),
      .count     (drop_count),
      .half_flag (drop_count_half_flag)
   );

   // ******************************
   // Indirect csr window
   // ******************************
   logic                 busy_q;
   logic                 dir_q;
   logic [7:0]           caddr_q;
   hmfs_pkg::hmfs_word_t cdata_q;
   // Writes during a running access are dropped, so the internal
   // port never sees its address or data move under it
   wire  cmd_wr   = wr && hit_cmd && !busy_q;
   wire  data_wr  = wr && hit_data && !busy_q;
   wire  start    = cmd_wr &&
                    link.wdata[`HMFS_CMD_BUSY_BIT];
   wire  finish   = busy_q && csr_ack;

   always_ff @(posedge link.pclk or negedge link.presetn) begin
      if (!link.presetn) begin
         busy_q  <= 1'b0;
         dir_q   <= 1'b0;
         caddr_q <= 8'h00;
      end else if (cmd_wr) begin
         busy_q  <= link.wdata[`HMFS_CMD_BUSY_BIT];
         dir_q   <= link.wdata[`HMFS_CMD_DIR_BIT];
         caddr_q <= link.wdata[7:0];
      end else if (finish) begin
         busy_q  <= 1'b0;
      end
   end

   always_ff @(posedge link.pclk or negedge link.presetn) begin
      if (!link.presetn) begin
         cdata_q <= 32'h00000000;
      end else if (finish && dir_q) begin
         cdata_q <= csr_rdata;
      end else if (data_wr) begin
         cdata_q <= link.wdata;
      end
   end

   assign csr_req              = busy_q;
   assign csr_access_direction = dir_q;
   assign csr_addr             = caddr_q;
   assign csr_wdata            = cdata_q;

   // ******************************
   // Read mux and answer
   // ******************************
   hmfs_pkg::hmfs_word_t rd_mux;
   assign rd_mux =
      hit_rxo  ? {8'h00, rx_status_used_dwords, rx_used_q} :
      hit_txs  ? {8'h00, tx_status_used_dwords, tx_free_q} :
      hit_drop ? drop_count :
      hit_cmd  ? {busy_q, dir_q, 22'h000000, caddr_q} :
      hit_data ? cdata_q :
                 32'h00000000;

   always_ff @(posedge link.pclk or negedge link.presetn) begin
      if (!link.presetn) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q   <= take;
         rdata_q <= rd ? rd_mux : rdata_q;
      end
   end

   assign link.ack   = ack_q;
   assign link.rdata = rdata_q;
endmodule

// ==== rtl/hmfs_host.sv ====
`timescale 1ns/100ps
`include "hmfs_defines.svh"
module hmfs_host (
   // Register window
   hmfs_link_if.host                 link,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output hmfs_pkg::hmfs_word_t      prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Interrupt
   output logic                      irq
);
   // ******************************
   // APB decode
   // ******************************
   wire setup = psel && !penable;
   wire wr    = psel && penable && pwrite;
   wire h_cmd = (paddr == `HMFS_H_COMMAND);
   wire h_adr = (paddr == `HMFS_H_ADDRESS);
   wire h_wd  = (paddr == `HMFS_H_WDATA);
   wire h_rd  = (paddr == `HMFS_H_RDATA);
   wire h_st  = (paddr == `HMFS_H_STATUS);
   wire h_is  = (paddr == `HMFS_H_IRQ_STATUS);
   wire h_ic  = (paddr == `HMFS_H_IRQ_CLEAR);
   wire h_ie  = (paddr == `HMFS_H_IRQ_ENABLE);
   wire mapped = h_cmd || h_adr || h_wd || h_rd ||
                 h_st || h_is || h_ic || h_ie;

   hmfs_pkg::hmfs_link_state_t state_q;
   logic                       op_we_q;
   logic [7:0]                 addr_q;
   hmfs_pkg::hmfs_word_t       wdata_q;
   hmfs_pkg::hmfs_word_t       rdata_q;
   logic                       csr_busy_q;
   logic [1:0]                 irq_st_q;
   logic [1:0]                 irq_en_q;
   hmfs_pkg::hmfs_word_t       prdata_q;

   // ******************************
   // Order acceptance
   // ******************************
   wire go       = wr && h_cmd && pwdata[`HMFS_H_GO_BIT];
   wire go_we    = pwdata[`HMFS_H_WRITE_BIT];
   wire win_addr = (addr_q == `HMFS_CSR_COMMAND) ||
                   (addr_q == `HMFS_CSR_DATA);
   // Window writes are refused, not queued, while the device is still busy
   wire blocked  = go_we && win_addr && csr_busy_q;
   wire idle     = (state_q == hmfs_pkg::hmfs_idle);
   wire launch   = go && idle && !blocked;
   wire refused  = go && !(idle && !blocked);
   wire done     = !idle && link.ack;

   always_ff @(posedge link.pclk or negedge link.presetn) begin
      if (!link.presetn) begin
         state_q <= hmfs_pkg::hmfs_idle;
         op_we_q <= 1'b0;
      end else begin
         case (state_q)
            hmfs_pkg::hmfs_idle: begin
               if (launch) begin
                  state_q <= hmfs_pkg::hmfs_access;
                  op_we_q <= go_we;
               end
            end
            hmfs_pkg::hmfs_access: begin
               if (link.ack) begin
                  state_q <= hmfs_pkg::hmfs_idle;
               end
            end
            default: state_q <= hmfs_pkg::hmfs_idle;
         endcase
      end
   end

   // ******************************
   // Busy shadow of the window
   // ******************************
   wire wr_cmd_done = done && op_we_q && (addr_q == `HMFS_CSR_COMMAND);
   wire rd_cmd_done = done && !op_we_q &&
                      (addr_q == `HMFS_CSR_COMMAND);

   always_ff @(posedge link.pclk or negedge link.presetn) begin
      if (!link.presetn) begin
         csr_busy_q <= 1'b0;
      end else if (wr_cmd_done) begin
         csr_busy_q <= wdata_q[`HMFS_CMD_BUSY_BIT];
      end else if (rd_cmd_done) begin
         csr_busy_q <= link.rdata[`HMFS_CMD_BUSY_BIT];
      end
   end

   // ******************************
   // Software registers
   // ******************************
   // Address and data stay frozen during an access
   always_ff @(posedge link.pclk or negedge link.presetn) begin
      if (!link.presetn) begin
         addr_q  <= 8'h00;
         wdata_q <= 32'h00000000;
         rdata_q <= 32'h00000000;
         irq_en_q <= 2'b00;
      end else begin
         if (wr && h_adr && idle) begin
            addr_q <= pwdata[7:0];
         end
         if (wr && h_wd && idle) begin
            wdata_q <= pwdata;
         end
         if (done && !op_we_q) begin
            rdata_q <= link.rdata;
         end
         if (wr && h_ie) begin
            irq_en_q <= pwdata[1:0];
         end
      end
   end

   // Set wins over a clear in the same cycle
   wire [1:0] irq_set = {refused, done};
   wire [1:0] irq_clr = (wr && h_ic) ? pwdata[1:0] : 2'b00;

   always_ff @(posedge link.pclk or negedge link.presetn) begin
      if (!link.presetn) begin
         irq_st_q <= 2'b00;
      end else begin
         irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
      end
   end

   assign irq = |(irq_st_q & irq_en_q);

   // ******************************
   // APB answer
   // ******************************
   hmfs_pkg::hmfs_word_t rd_mux;
   assign rd_mux =
      h_cmd ? {31'h00000000, !idle} :
      h_adr ? {24'h000000, addr_q} :
      h_wd  ? wdata_q :
      h_rd  ? rdata_q :
      h_st  ? {30'h00000000, csr_busy_q, !idle} :
      h_is  ? {30'h00000000, irq_st_q} :
      h_ie  ? {30'h00000000, irq_en_q} :
              32'h00000000;

   always_ff @(posedge link.pclk or negedge link.presetn) begin
      if (!link.presetn) begin
         prdata_q <= 32'h00000000;
      end else if (setup) begin
         prdata_q <= rd_mux;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   assign link.req   = !idle;
   assign link.we    = op_we_q;
   assign link.addr  = addr_q;
   assign link.wdata = wdata_q;
endmodule

// ==== tb/hmfs_link_sva.sv ====
`timescale 1ns/100ps
module hmfs_link_sva (
   // Clock and reset
   input wire logic                 pclk,
   input wire logic                 presetn,
   // Link
   input wire logic                 req,
   input wire logic                 we,
   input wire hmfs_pkg::hmfs_addr_t addr,
   input wire hmfs_pkg::hmfs_word_t wdata,
   input wire hmfs_pkg::hmfs_word_t rdata,
   input wire logic                 ack
);
   // ****************
   // Link checks
   // ****************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ack_follows_req: assert property ($rose(req) |=> ack)
      else $error("request not answered next cycle");
   chk_ack_one_cycle: assert property (ack |=> !ack && !req)
      else $error("answer or request held too long");
   chk_ack_has_cause: assert property (ack |-> req && $past(req) && !$past(ack))
      else $error("answer without a taken request");
   chk_rdata_on_read: assert property ($changed(rdata) |-> ack && !$past(we))
      else $error("read data moved outside a read answer");
   chk_rx_top_zero: assert property (ack && !$past(we) && $past(addr) == 8'h7C
      |-> rdata[31:24] == 8'h00)
      else $error("rx occupancy top byte not zero");
   chk_tx_top_zero: assert property (ack && !$past(we) && $past(addr) == 8'h80
      |-> rdata[31:24] == 8'h00)
      else $error("tx space top byte not zero");
   chk_cmd_gap_zero: assert property (ack && !$past(we) && $past(addr) == 8'hA4
      |-> rdata[29:8] == 22'h0)
      else $error("command reserved bits not zero");
   chk_unmapped_zero: assert property (ack && !$past(we) && !($past(addr) inside
      {8'h7C, 8'h80, 8'hA0, 8'hA4, 8'hA8}) |-> rdata == 32'h0)
      else $error("unmapped read not zero");
endmodule

// ==== tb/host_mac_fifo_status_csr_window_bench.sv ====
`timescale 1ns/100ps
`define CHECK_EQ(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
   bad_count++; $display("[ERR] %0t got %h expected %h", $time, got, exp); \
   end end
module host_mac_fifo_status_csr_window_bench;
   logic                 pclk, presetn, psel, penable, pwrite, pready;
   logic                 pslverr, irq, perr, seen_dir, drop_count_half_flag;
   logic [11:0]          paddr;
   logic [31:0]          pwdata;
   logic [7:0]           rx_status_used_dwords, tx_status_used_dwords;
   logic                 rx_frame_valid, rx_data_read_valid, rx_frame_dropped;
   logic                 tx_data_push_valid, tx_data_sent_valid;
   logic [15:0]          rx_frame_len, rx_data_read_bytes;
   logic [15:0]          tx_data_push_bytes, tx_data_sent_bytes;
   logic                 csr_req, csr_access_direction, csr_ack, csr_hold;
   logic [7:0]           csr_addr, seen_addr;
   hmfs_pkg::hmfs_word_t prdata, csr_wdata, csr_rdata, seen_wdata, rd;
   int                   bad_count, total_checks, cnt, csr_delay;
   hmfs_link_if link (.pclk(pclk), .presetn(presetn));
   hmfs_host u_hmfs_host (.link(link), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq));
   hmfs_device u_hmfs_device (.link(link),
      .rx_status_used_dwords(rx_status_used_dwords),
      .rx_frame_valid(rx_frame_valid), .rx_frame_len(rx_frame_len),
      .rx_data_read_valid(rx_data_read_valid),
      .rx_data_read_bytes(rx_data_read_bytes),
      .rx_frame_dropped(rx_frame_dropped),
      .tx_status_used_dwords(tx_status_used_dwords),
      .tx_data_push_valid(tx_data_push_valid),
      .tx_data_push_bytes(tx_data_push_bytes),
      .tx_data_sent_valid(tx_data_sent_valid),
      .tx_data_sent_bytes(tx_data_sent_bytes),
      .drop_count_half_flag(drop_count_half_flag), .csr_req(csr_req),
      .csr_access_direction(csr_access_direction), .csr_addr(csr_addr),
      .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .csr_ack(csr_ack));
   hmfs_link_sva u_hmfs_link_sva (.pclk(pclk), .presetn(presetn),
      .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
      .rdata(link.rdata), .ack(link.ack));
   // ****************
   // Internal csr responder
   // ****************
   // Idle read data toggles so a stale sample cannot pass
   always @(posedge pclk) begin
      csr_ack <= 1'b0;
      csr_rdata <= ~csr_rdata;
      if (csr_req && !csr_ack && !csr_hold) begin
         cnt <= cnt + 1;
         if (cnt >= csr_delay) begin
            csr_ack <= 1'b1;
            csr_rdata <= {24'hC5A000, csr_addr};
            seen_addr <= csr_addr;
            seen_dir <= csr_access_direction;
            seen_wdata <= csr_wdata;
            cnt <= 0;
         end
      end
   end
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // ****************
   // Bus tasks
   // ****************
   // One idle cycle after each transfer keeps psel from two drives per step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic link_op(input logic w, input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, 12'h004, {24'h0, a});
      if (w) apb(1'b1, 12'h008, d);
      apb(1'b1, 12'h000, {30'h0, w, 1'b1});
      do apb(1'b0, 12'h014, 32'h0); while (rd[0] !== 1'b1);
      apb(1'b1, 12'h018, 32'h1);
      if (!w) apb(1'b0, 12'h00C, 32'h0);
   endtask
   task automatic wait_idle;
      do link_op(1'b0, 8'hA4, 32'h0); while (rd[31] !== 1'b0);
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset;
      `CHECK_EQ(irq, 1'b0)
      link_op(1'b0, 8'h80, 32'h0); `CHECK_EQ(rd, 32'h00001200)
      link_op(1'b0, 8'hA0, 32'h0); `CHECK_EQ(rd, 32'h0)
      link_op(1'b0, 8'hA8, 32'h0); `CHECK_EQ(rd, 32'h0)
      link_op(1'b0, 8'h90, 32'h0); `CHECK_EQ(rd, 32'h0)
      apb(1'b0, 12'h100, 32'h0); `CHECK_EQ(perr, 1'b1)
   endtask
   task automatic t_fifo;
      rx_status_used_dwords <= 8'h5A;
      tx_status_used_dwords <= 8'h33;
      rx_frame_valid <= 1'b1;
      rx_frame_len <= 16'h0005;
      tx_data_push_valid <= 1'b1;
      tx_data_push_bytes <= 16'h0100;
      @(posedge pclk);
      rx_frame_len <= 16'h0040;
      tx_data_push_valid <= 1'b0;
      tx_data_sent_valid <= 1'b1;
      tx_data_sent_bytes <= 16'h0040;
      @(posedge pclk);
      rx_frame_valid <= 1'b0;
      tx_data_sent_valid <= 1'b0;
      rx_data_read_valid <= 1'b1;
      rx_data_read_bytes <= 16'h0006;
      @(posedge pclk);
      rx_data_read_valid <= 1'b0;
      // 5 rounds to 8, plus 64, less 6 read out
      link_op(1'b0, 8'h7C, 32'h0); `CHECK_EQ(rd, 32'h005A0042)
      link_op(1'b0, 8'h80, 32'h0); `CHECK_EQ(rd, 32'h00331140)
   endtask
   task automatic t_drop;
      rx_frame_dropped <= 1'b1;
      repeat (3) @(posedge pclk);
      rx_frame_dropped <= 1'b0;
      link_op(1'b0, 8'hA0, 32'h0); `CHECK_EQ(rd, 32'h3)
      link_op(1'b0, 8'hA0, 32'h0); `CHECK_EQ(rd, 32'h0)
   endtask
   task automatic t_ind_write;
      link_op(1'b1, 8'hA8, 32'hDEADBEEF);
      link_op(1'b1, 8'hA4, 32'h80000012);
      wait_idle;
      `CHECK_EQ(seen_dir, 1'b0)
      `CHECK_EQ(seen_addr, 8'h12)
      `CHECK_EQ(seen_wdata, 32'hDEADBEEF)
      link_op(1'b0, 8'hA8, 32'h0); `CHECK_EQ(rd, 32'hDEADBEEF)
   endtask
   task automatic t_ind_read;
      csr_delay <= 60;
      link_op(1'b1, 8'hA4, 32'hC0000034);
      link_op(1'b0, 8'hA4, 32'h0); `CHECK_EQ(rd, 32'hC0000034)
      wait_idle;
      `CHECK_EQ(seen_dir, 1'b1)
      link_op(1'b0, 8'hA8, 32'h0); `CHECK_EQ(rd, 32'hC5A00034)
      csr_delay <= 0;
   endtask
   task automatic t_refuse_irq;
      csr_hold <= 1'b1;
      apb(1'b1, 12'h01C, 32'h0);
      link_op(1'b1, 8'hA4, 32'h80000001);
      apb(1'b1, 12'h004, 32'hA8);
      apb(1'b1, 12'h008, 32'h1);
      apb(1'b1, 12'h000, 32'h3);
      apb(1'b0, 12'h014, 32'h0); `CHECK_EQ(rd[1:0], 2'b10)
      `CHECK_EQ(irq, 1'b0)
      apb(1'b1, 12'h01C, 32'h2); `CHECK_EQ(irq, 1'b1)
      apb(1'b1, 12'h018, 32'h2); `CHECK_EQ(irq, 1'b0)
      csr_hold <= 1'b0;
      wait_idle;
      link_op(1'b0, 8'hA8, 32'h0); `CHECK_EQ(rd, 32'hC5A00034)
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      end_of_test;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, csr_hold} = '0;
      {rx_status_used_dwords, tx_status_used_dwords, rx_frame_len} = '0;
      {rx_frame_valid, rx_data_read_valid, rx_frame_dropped} = '0;
      {tx_data_push_valid, tx_data_sent_valid, rx_data_read_bytes} = '0;
      {tx_data_push_bytes, tx_data_sent_bytes, csr_rdata} = '0;
      {bad_count, total_checks, cnt, csr_delay} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_fifo;
      t_drop;
      t_ind_write;
      t_ind_read;
      t_refuse_irq;
      end_of_test;
   end
endmodule
